// *** rtl/flash_id_secure_dev.sv ***
// Purpose: Flash-side interpreter for identity and secure page commands
// Assumes: Link pins sampled by sys_clk_in; sclk much slower than it
// Notes:   Secure page read (48h) and status read (05h) also served
// Functional notes
// - Dual identity: 92h, zero address, two lines
// - Dual identity data two bits, falling, MSB
// - Host drives continuous-mode byte all ones
// - Quad identity: 94h, zero address, four lines
// - Quad identity data four bits, falling, MSB
// - Identity bytes alternate until chip select rises
// - 4Bh, four dummy bytes, 64-bit number out
// - 9Fh returns maker, type, capacity bytes
// - 5Ah, address, eight dummies, data clock 40
// - Host keeps upper address zero, low selects byte
// - Table read, secure erase/program single-line only
// - Secure erase needs write enable latch set
// - Address bits 15..12 pick register one-three
// - Erase runs only if select rises on boundary
// - Erase self-timed, busy set, status still readable
// - Erase end clears busy and enable latch
// - Lock bit blocks erase and program forever
// - Secure program 42h, needs enable latch set
// - Host sends command, address, at least one byte
// - Host holds select low through program data
// - Program suspend refuses secure program
// - Erase suspend refuses secure erase
`timescale 1ns/100ps
`include "flash_link_defs.svh"
module flash_id_secure_dev #(
  parameter logic [7:0]  MAKER_ID     = 8'h5c, // Arbitrary identity value
  parameter logic [7:0]  DEVICE_ID    = 8'h11, // Arbitrary identity value
  parameter logic [7:0]  MEM_TYPE     = 8'h60, // Arbitrary identity value
  parameter logic [7:0]  CAPACITY     = 8'h12, // Arbitrary identity value
  parameter logic [63:0] UNIQUE_ID    = 64'h0123_4567_89ab_cdef,
  parameter logic [7:0]  PID_FILL     = 8'hff,
  parameter int          ERASE_CYCLES = `SEC_ERASE_CYCLES,
  parameter int          PROG_CYCLES  = `SEC_PROG_CYCLES
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  spi_link_if.flash       link,
  input  wire logic [2:0] secure_page_lock_bits_in,
  input  wire logic       prog_suspended_in,
  input  wire logic       erase_suspended_in,
  output logic            busy_out,
  output logic            write_enable_latch_bit_out
);
  flash_link_pkg::frame_state_t st_reg;
  logic [1:0]  cs_sync, clk_sync, sus_m, sus_s;
  logic [3:0]  io_m, io_s;
  logic [2:0]  lk_m, lk_s;
  logic        clk_d, cs_d, rise, fall, frame, cs_rise, serial_in_line;
  logic [7:0]  cmd_reg, cmd_next, byte_reg, ptr_reg;
  logic [31:0] sh_reg, sh_next;
  logic [11:0] cnt_reg;
  logic [1:0]  sel_reg, er_sel_reg;
  logic [2:0]  dbit_reg;
  logic        erase_arm_reg, prog_used_reg, erasing_reg;
  logic [15:0] busy_cnt_reg;
  logic [63:0] sr_reg, load;
  logic [6:0]  left_reg, load_len;
  logic [2:0]  w;
  logic [7:0]  sec_mem [0:767];

  // Lines per clock for each command; the rest use one line
  function automatic logic [2:0] lanes(input logic [7:0] c);
    if (c == `OP_ID_DUAL) return 3'd2;
    if (c == `OP_ID_QUAD) return 3'd4;
    return 3'd1;
  endfunction

  // Rising-edge count at which the address phase ends
  function automatic logic [11:0] addr_end(input logic [7:0] c);
    case (c)
      `OP_ID_DUAL: return 12'd23;
      `OP_ID_QUAD: return 12'd15;
      `OP_UID, `OP_PID, `OP_SEC_READ: return 12'd39;
      default: return 12'd31;
    endcase
  endfunction

  // Register number 0..2 from a 24-bit address, valid flag on top
  function automatic logic [2:0] sel_of(input logic [23:0] a);
    logic ok;
    ok = (a[23:16] == 8'h00) && (a[11:8] == 4'h0) &&
         (a[15:12] != 4'h0) && (a[15:12] <= 4'h3);
    return {ok, a[13:12] - 2'd1};
  endfunction

  // Pin value for the top lanes of an output word
  function automatic logic [3:0] top(input logic [63:0] v,
                                     input logic [2:0] n);
    if (n == 3'd1) return {2'b00, v[63], 1'b0};
    if (n == 3'd2) return {2'b00, v[63:62]};
    return v[63:60];
  endfunction

  // Two flip-flops on every pin and strap before use
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cs_sync <= 2'b11;
      clk_sync <= 2'b00;
      io_m <= 4'h0;
      io_s <= 4'h0;
      lk_m <= 3'b000;
      lk_s <= 3'b000;
      sus_m <= 2'b00;
      sus_s <= 2'b00;
      clk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], link.cs_n};
      clk_sync <= {clk_sync[0], link.sclk};
      io_m <= link.host_io;
      io_s <= io_m;
      lk_m <= secure_page_lock_bits_in;
      lk_s <= lk_m;
      sus_m <= {prog_suspended_in, erase_suspended_in};
      sus_s <= sus_m;
      clk_d <= clk_sync[1];
      cs_d <= cs_sync[1];
    end
  end

  assign rise = clk_sync[1] & ~clk_d;
  assign fall = ~clk_sync[1] & clk_d;
  assign frame = ~cs_sync[1];
  assign cs_rise = cs_sync[1] & ~cs_d;
  assign serial_in_line = io_s[0];
  assign cmd_next = {cmd_reg[6:0], serial_in_line};
  assign w = lanes(cmd_reg);

  // Address shift at the command's line count
  always_comb begin
    if (w == 3'd2) sh_next = {sh_reg[29:0], io_s[1:0]};
    else if (w == 3'd4) sh_next = {sh_reg[27:0], io_s};
    else sh_next = {sh_reg[30:0], serial_in_line};
  end

  // Frame sequencing; state, counters and flags restart while chip select is high
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !frame) begin
      st_reg <= flash_link_pkg::F_CMD;
      cnt_reg <= 12'd0;
      dbit_reg <= 3'd0;
      erase_arm_reg <= 1'b0;
      prog_used_reg <= 1'b0;
      if (rst_in) begin
        cmd_reg <= 8'h00;
        sh_reg <= 32'h0;
        sel_reg <= 2'd0;
        ptr_reg <= 8'h00;
        byte_reg <= 8'h00;
      end
    end else if (rise) begin
      if (cnt_reg != 12'hfff) cnt_reg <= cnt_reg + 12'd1;
      erase_arm_reg <= 1'b0;
      case (st_reg)
        flash_link_pkg::F_CMD: begin
          cmd_reg <= cmd_next;
          if (cnt_reg == 12'd7) begin
            if (busy_out && cmd_next != `OP_RDSR)
              st_reg <= flash_link_pkg::F_SKIP;
            else if (cmd_next == `OP_RDSR || cmd_next == `OP_JID)
              st_reg <= flash_link_pkg::F_OUT;
            else if (cmd_next == `OP_ID_DUAL || cmd_next == `OP_ID_QUAD ||
                     cmd_next == `OP_UID || cmd_next == `OP_PID ||
                     cmd_next == `OP_SEC_ERASE ||
                     cmd_next == `OP_SEC_PROG || cmd_next == `OP_SEC_READ)
              st_reg <= flash_link_pkg::F_ADDR;
            else
              st_reg <= flash_link_pkg::F_SKIP;
          end
        end
        flash_link_pkg::F_ADDR: begin
          sh_reg <= sh_next;
          if (cnt_reg == addr_end(cmd_reg)) begin
            case (cmd_reg)
              `OP_SEC_ERASE: begin
                sel_reg <= 2'(sel_of(sh_next[23:0]));
                erase_arm_reg <= write_enable_latch_bit_out &&
                  sel_of(sh_next[23:0]) >= 3'd4 &&
                  !lk_s[2'(sel_of(sh_next[23:0]))] &&
                  !sus_s[0];
                st_reg <= flash_link_pkg::F_SKIP;
              end
              `OP_SEC_PROG: begin
                sel_reg <= 2'(sel_of(sh_next[23:0]));
                ptr_reg <= sh_next[7:0];
                if (write_enable_latch_bit_out &&
                    sel_of(sh_next[23:0]) >= 3'd4 &&
                    !lk_s[2'(sel_of(sh_next[23:0]))] &&
                    !sus_s[1])
                  st_reg <= flash_link_pkg::F_WDATA;
                else
                  st_reg <= flash_link_pkg::F_SKIP;
              end
              `OP_PID, `OP_SEC_READ: begin
                sel_reg <= 2'(sel_of(sh_next[31:8]));
                ptr_reg <= sh_next[15:8];
                st_reg <= flash_link_pkg::F_OUT;
              end
              default: st_reg <= flash_link_pkg::F_OUT;
            endcase
          end
        end
        flash_link_pkg::F_WDATA: begin
          byte_reg <= {byte_reg[6:0], serial_in_line};
          dbit_reg <= dbit_reg + 3'd1;
          if (dbit_reg == 3'd7) begin
            ptr_reg <= ptr_reg + 8'd1; // Wraps inside the 256-byte page
            prog_used_reg <= 1'b1;
          end
        end
        default: st_reg <= st_reg;
      endcase
    end else if (fall && st_reg == flash_link_pkg::F_OUT &&
                 left_reg == 7'd0 &&
                 (cmd_reg == `OP_PID || cmd_reg == `OP_SEC_READ)) begin
      ptr_reg <= ptr_reg + 8'd1;
    end
  end

  // Next output word for the running command
  always_comb begin
    load = {4{MAKER_ID, DEVICE_ID}};
    load_len = 7'd64;
    case (cmd_reg)
      `OP_RDSR: begin
        load = 64'h0;
        load[56 + `SR_BUSY_BIT] = busy_out;
        load[56 + `SR_WEL_BIT] = write_enable_latch_bit_out;
        load_len = 7'd8;
      end
      `OP_JID: begin
        load = {MAKER_ID, MEM_TYPE, CAPACITY, 40'h0};
        load_len = 7'd24;
      end
      `OP_UID: load = UNIQUE_ID;
      `OP_PID: begin
        load = {PID_FILL, 56'h0};
        load_len = 7'd8;
      end
      `OP_SEC_READ: begin
        load = {sec_mem[{sel_reg, ptr_reg}], 56'h0};
        load_len = 7'd8;
      end
      default: load_len = 7'd64;
    endcase
  end

  // Output shifter, updated on falling link clock edges only
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !frame) begin
      sr_reg <= 64'h0;
      left_reg <= 7'd0;
      link.dev_io <= 4'h0;
      link.dev_oe <= 4'h0; // Released once the synchronised select is high
    end else if (fall && st_reg == flash_link_pkg::F_OUT) begin
      if (w == 3'd4) link.dev_oe <= 4'hf;
      else if (w == 3'd2) link.dev_oe <= 4'h3;
      else link.dev_oe <= 4'h2;
      if (left_reg == 7'd0) begin
        sr_reg <= load;
        left_reg <= load_len - {4'd0, w};
        link.dev_io <= top(load, w);
      end else begin
        sr_reg <= sr_reg << w;
        left_reg <= left_reg - {4'd0, w};
        link.dev_io <= top(sr_reg << w, w);
      end
    end
  end

  // Write enable latch: set by 06h, cleared when a cycle ends
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      write_enable_latch_bit_out <= 1'b0;
    end else if (rise && st_reg == flash_link_pkg::F_CMD &&
                 cnt_reg == 12'd7 && cmd_next == `OP_WREN && !busy_out) begin
      write_enable_latch_bit_out <= 1'b1;
    end else if (busy_out && busy_cnt_reg == 16'd0) begin
      write_enable_latch_bit_out <= 1'b0;
    end
  end

  // Self-timed busy window, started by chip select rising
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      erasing_reg <= 1'b0;
      busy_cnt_reg <= 16'd0;
      er_sel_reg <= 2'd0;
    end else if (cs_rise && erase_arm_reg) begin
      busy_out <= 1'b1;
      erasing_reg <= 1'b1;
      busy_cnt_reg <= 16'(ERASE_CYCLES - 1);
      er_sel_reg <= sel_reg;
    end else if (cs_rise && prog_used_reg) begin
      busy_out <= 1'b1;
      busy_cnt_reg <= 16'(PROG_CYCLES - 1);
    end else if (busy_out) begin
      if (busy_cnt_reg == 16'd0) begin
        busy_out <= 1'b0;
        erasing_reg <= 1'b0;
      end else begin
        busy_cnt_reg <= busy_cnt_reg - 16'd1;
      end
    end
  end

  // Secure pages: erase one byte a cycle, program can only clear bits
  always_ff @(posedge sys_clk_in) begin
    if (erasing_reg && busy_cnt_reg < 16'd256) begin
      sec_mem[{er_sel_reg, busy_cnt_reg[7:0]}] <= 8'hff;
    end else if (rise && st_reg == flash_link_pkg::F_WDATA &&
                 dbit_reg == 3'd7) begin
      sec_mem[{sel_reg, ptr_reg}] <= sec_mem[{sel_reg, ptr_reg}] &
                                     {byte_reg[6:0], serial_in_line};
    end
  end
endmodule

// *** rtl/flash_link_defs.svh ***
// Purpose: Constants shared by both ends of the serial flash link
// Assumes: 200 MHz system clock on both ends
// Notes:   Definitions only
`ifndef FLASH_LINK_DEFS_SVH
`define FLASH_LINK_DEFS_SVH

// Instruction codes
`define OP_WREN       8'h06
`define OP_RDSR       8'h05
`define OP_ID_DUAL    8'h92
`define OP_ID_QUAD    8'h94
`define OP_UID        8'h4b
`define OP_JID        8'h9f
`define OP_PID        8'h5a
`define OP_SEC_ERASE  8'h44
`define OP_SEC_PROG   8'h42
`define OP_SEC_READ   8'h48

// Status byte fields and continuous-mode byte value
`define SR_BUSY_BIT   0
`define SR_WEL_BIT    1
`define MODE_BYTE     8'hff

// Host register offsets and control fields
`define HREG_CMD       4'h0
`define HREG_ADDR      4'h4
`define HREG_DATA      4'h8
`define HREG_CTRL      4'hc
`define CTRL_START_BIT 0
`define CTRL_BYTE_BIT  1
`define CTRL_END_BIT   2

// Timing
`define SYS_CLK_PERIOD_NS  5
`define CS_HIGH_TIME_NS    50
`define CS_HIGH_CYCLES     \
  ((`CS_HIGH_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define SEC_ERASE_TIME_NS  2000
`define SEC_ERASE_CYCLES   \
  ((`SEC_ERASE_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define SEC_PROG_TIME_NS   1000
`define SEC_PROG_CYCLES    \
  ((`SEC_PROG_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define SCLK_HALF_CYCLES   8

`endif

// *** rtl/flash_link_pkg.sv ***
// Purpose: Types shared by both ends of the serial flash link
// Assumes: Nothing beyond the defs header
// Notes:   One-hot state codes
package flash_link_pkg;
  typedef enum logic [4:0] {
    F_CMD   = 5'b00001,
    F_ADDR  = 5'b00010,
    F_OUT   = 5'b00100,
    F_WDATA = 5'b01000,
    F_SKIP  = 5'b10000
  } frame_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW  = 4'b0010,
    H_HIGH = 4'b0100,
    H_HOLD = 4'b1000
  } host_state_t;
endpackage

// *** rtl/spi_link_if.sv ***
// Purpose: Pins between the host controller and the flash
// Assumes: Each end reads the other end's data lines; enables are only checked
// Notes:   Line 0 is serial_in_line; line 1 carries single-line output
`timescale 1ns/100ps
interface spi_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io;
  logic [3:0] host_oe;
  logic [3:0] dev_io;
  logic [3:0] dev_oe;

  modport host  (output cs_n, sclk, host_io, host_oe,
                 input  dev_io, dev_oe);
  modport flash (input  cs_n, sclk, host_io, host_oe,
                 output dev_io, dev_oe);
endinterface

// *** rtl/flash_link_host.sv ***
// Purpose: Host controller that drives the flash link from registers
// Assumes: Software waits for the engine to go idle between orders
// Notes:   Link clock is a divided system clock, mode 0
`timescale 1ns/100ps
`include "flash_link_defs.svh"
module flash_link_host #(
  parameter int HALF = `SCLK_HALF_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  spi_link_if.host         link
);
  flash_link_pkg::host_state_t hs_reg;
  logic [7:0]  cmd_reg, txdata_reg, rx_reg;
  logic [23:0] addr_reg;
  logic [31:0] tx_reg;
  logic [5:0]  left_reg;
  logic [2:0]  w_reg;
  logic [7:0]  half_reg;
  logic        open_reg, pre_reg;
  logic [3:0]  io_m, io_s;
  logic        go_start, go_byte, go_end;

  // Lines used for data bytes of a command
  function automatic logic [2:0] lanes(input logic [7:0] c);
    if (c == `OP_ID_DUAL) return 3'd2;
    if (c == `OP_ID_QUAD) return 3'd4;
    return 3'd1;
  endfunction

  // Drive pattern for the top lanes of the transmit word
  function automatic logic [3:0] pick(input logic [31:0] v,
                                      input logic [2:0] n);
    if (n == 3'd1) return {3'b000, v[31]};
    if (n == 3'd2) return {2'b00, v[31:30]};
    return v[31:28];
  endfunction

  assign go_start = reg_wr_in && reg_addr_in == `HREG_CTRL &&
                    reg_wdata_in[`CTRL_START_BIT] && !open_reg;
  assign go_byte = reg_wr_in && reg_addr_in == `HREG_CTRL &&
                   reg_wdata_in[`CTRL_BYTE_BIT] && open_reg;
  assign go_end = reg_wr_in && reg_addr_in == `HREG_CTRL &&
                  reg_wdata_in[`CTRL_END_BIT] && open_reg;

  // Device lines pass two flip-flops before sampling
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      io_m <= 4'h0;
      io_s <= 4'h0;
    end else begin
      io_m <= link.dev_io;
      io_s <= io_m;
    end
  end

  // Software registers; orders are ignored while the engine runs
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cmd_reg <= 8'h00;
      addr_reg <= 24'h0;
      txdata_reg <= 8'h00;
      reg_rdata_out <= 32'h0;
    end else begin
      if (reg_wr_in && reg_addr_in == `HREG_CMD)
        cmd_reg <= reg_wdata_in[7:0];
      else if (reg_wr_in && reg_addr_in == `HREG_ADDR)
        addr_reg <= reg_wdata_in[23:0];
      else if (reg_wr_in && reg_addr_in == `HREG_DATA)
        txdata_reg <= reg_wdata_in[7:0];
      if (!reg_rd_in) reg_rdata_out <= 32'h0;
      else if (reg_addr_in == `HREG_CMD) reg_rdata_out <= {24'h0, cmd_reg};
      else if (reg_addr_in == `HREG_ADDR) reg_rdata_out <= {8'h0, addr_reg};
      else if (reg_addr_in == `HREG_DATA) reg_rdata_out <= {24'h0, rx_reg};
      else if (reg_addr_in == `HREG_CTRL)
        reg_rdata_out <= {30'h0, open_reg,
                          hs_reg != flash_link_pkg::H_IDLE};
      else reg_rdata_out <= 32'h0;
    end
  end

  // Bit engine: low half drives, high half samples, then shifts
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hs_reg <= flash_link_pkg::H_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.host_io <= 4'h0;
      link.host_oe <= 4'h0;
      tx_reg <= 32'h0;
      rx_reg <= 8'h00;
      left_reg <= 6'd0;
      w_reg <= 3'd1;
      half_reg <= 8'd0;
      open_reg <= 1'b0;
      pre_reg <= 1'b0;
    end else begin
      case (hs_reg)
        flash_link_pkg::H_IDLE: begin
          half_reg <= 8'd0;
          if (go_start && open_reg == 1'b0) begin
            link.cs_n <= 1'b0;
            open_reg <= 1'b1;
            pre_reg <= 1'b1;
            tx_reg <= {cmd_reg, 24'h0};
            left_reg <= 6'd8;
            w_reg <= 3'd1;
            link.host_oe <= 4'h1;
            hs_reg <= flash_link_pkg::H_LOW;
          end else if (go_byte) begin
            tx_reg <= {txdata_reg, 24'h0};
            w_reg <= lanes(cmd_reg);
            left_reg <= 6'd8 >> (lanes(cmd_reg) >> 1);
            link.host_oe <= (cmd_reg == `OP_SEC_PROG) ? 4'h1 : 4'h0;
            hs_reg <= flash_link_pkg::H_LOW;
          end else if (go_end) begin
            link.cs_n <= 1'b1;
            open_reg <= 1'b0;
            link.host_oe <= 4'h0;
            hs_reg <= flash_link_pkg::H_HOLD;
          end
        end
        flash_link_pkg::H_LOW: begin
          link.host_io <= pick(tx_reg, w_reg);
          half_reg <= half_reg + 8'd1;
          if (half_reg == 8'(HALF - 1)) begin
            half_reg <= 8'd0;
            link.sclk <= 1'b1;
            hs_reg <= flash_link_pkg::H_HIGH;
          end
        end
        flash_link_pkg::H_HIGH: begin
          half_reg <= half_reg + 8'd1;
          if (half_reg == 8'(HALF - 1)) begin
            half_reg <= 8'd0;
            link.sclk <= 1'b0;
            tx_reg <= tx_reg << w_reg;
            left_reg <= left_reg - 6'd1;
            if (w_reg == 3'd1) rx_reg <= {rx_reg[6:0], io_s[1]};
            else if (w_reg == 3'd2) rx_reg <= {rx_reg[5:0], io_s[1:0]};
            else rx_reg <= {rx_reg[3:0], io_s};
            hs_reg <= flash_link_pkg::H_LOW;
            if (left_reg == 6'd1 && pre_reg) begin
              pre_reg <= 1'b0;
              w_reg <= lanes(cmd_reg);
              case (cmd_reg)
                `OP_ID_DUAL: begin
                  tx_reg <= {addr_reg, `MODE_BYTE};
                  left_reg <= 6'd16;
                  link.host_oe <= 4'h3;
                end
                `OP_ID_QUAD: begin
                  tx_reg <= {addr_reg, `MODE_BYTE};
                  left_reg <= 6'd8;
                  link.host_oe <= 4'hf;
                end
                `OP_UID, `OP_PID, `OP_SEC_READ: begin
                  tx_reg <= {addr_reg, 8'h00};
                  left_reg <= 6'd32;
                end
                `OP_SEC_ERASE, `OP_SEC_PROG: begin
                  tx_reg <= {addr_reg, 8'h00};
                  left_reg <= 6'd24;
                end
                default: begin
                  link.host_oe <= 4'h0;
                  hs_reg <= flash_link_pkg::H_IDLE;
                end
              endcase
            end else if (left_reg == 6'd1) begin
              link.host_oe <= 4'h0; // Hand lines back before device drives
              hs_reg <= flash_link_pkg::H_IDLE;
            end
          end
        end
        flash_link_pkg::H_HOLD: begin
          half_reg <= half_reg + 8'd1;
          if (half_reg == 8'(`CS_HIGH_CYCLES - 1))
            hs_reg <= flash_link_pkg::H_IDLE;
        end
        default: hs_reg <= flash_link_pkg::H_IDLE;
      endcase
    end
  end
endmodule

// *** bench/flash_link_sva.sv ***
// Purpose: Pin checks on the link between host and flash
// Assumes: Link clock halves of 8 system clocks
// Notes:   Busy and latch are judged by the bench
`timescale 1ns/100ps
module flash_link_sva (
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_io,
  input wire logic [3:0] dev_oe
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Turnaround must never let both ends drive one line
  AST_NO_FIGHT: assert property ((dev_oe & host_oe) == 4'h0)
    else $error("both ends drive a data line");
  AST_LANES: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("flash drives an odd lane set");
  AST_OE_OFF: assert property (cs_n [*5] |-> dev_oe == 4'h0)
    else $error("flash drives after deselect");
  AST_HOST_OFF: assert property (cs_n [*5] |-> host_oe == 4'h0)
    else $error("host drives after deselect");
  AST_CLK_IN_FRAME: assert property ($rose(sclk) |-> !cs_n)
    else $error("link clock rises while deselected");
  AST_HIGH_HALF: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high half is not 8 cycles");
  AST_OUT_STABLE: assert property (sclk && $past(sclk) |-> $stable(dev_io))
    else $error("flash output moves while clock high");
  AST_DESELECT: assert property ($rose(cs_n) |-> cs_n [*8] ##1 cs_n ##1 cs_n)
    else $error("select high time under 10 cycles");
  // Main traffic shapes
  COV_QUAD: cover property (dev_oe == 4'hf);
  COV_DUAL: cover property (dev_oe == 4'h3);
  COV_SINGLE: cover property (dev_oe == 4'h2);
endmodule

// *** bench/testbench.sv ***
// Purpose: Drives host registers and checks the flash answers
// Assumes: Engine busy is polled between orders
// Notes:   Program count shortened to keep the run brief
`timescale 1ns/100ps
`include "flash_link_defs.svh"
module testbench;
  localparam logic [7:0]  MK = 8'ha7, DV = 8'h3c, TY = 8'h41, CP = 8'h15;
  localparam logic [7:0]  PF = 8'h96;
  localparam logic [63:0] UID = 64'h1122_3344_5566_7788;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [2:0]  lock = 3'h0;
  logic        susp = 1'b0;
  logic        esus = 1'b0;
  logic        busy_out;
  logic        write_enable_latch_bit;
  logic [31:0] rdv;
  int          err_count = 0;
  int          check_count = 0;
  spi_link_if link ();
  flash_link_host u_flash_link_host (.sys_clk_in, .rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .link(link));
  flash_id_secure_dev #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(TY),
    .CAPACITY(CP), .UNIQUE_ID(UID), .PID_FILL(PF), .PROG_CYCLES(4))
    u_flash_id_secure_dev (.sys_clk_in, .rst_in, .link(link),
    .secure_page_lock_bits_in(lock), .prog_suspended_in(susp),
    .erase_suspended_in(esus), .busy_out, .write_enable_latch_bit_out(write_enable_latch_bit));
  flash_link_sva u_flash_link_sva (.sys_clk_in, .rst_in, .cs_n(link.cs_n),
    .sclk(link.sclk), .host_io(link.host_io), .host_oe(link.host_oe),
    .dev_io(link.dev_io), .dev_oe(link.dev_oe));
  // 200 MHz system clock
  always #2.5 sys_clk_in = ~sys_clk_in;
  task automatic give_verdict();
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 rdv = reg_rdata_out;
  endtask
  // Bounded poll, so a stuck engine ends the run instead of hanging
  task automatic idle();
    for (int i = 0; i < 3000; i++) begin
      rd(`HREG_CTRL);
      if (rdv[0] === 1'b0) return;
    end
    err_count++;
    give_verdict();
  endtask
  task automatic busy_wait();
    for (int i = 0; i < 2000 && busy_out !== 1'b0; i++) @(posedge sys_clk_in);
    chk(busy_out, 0);
    // A cycle that never ends goes straight to the report
    if (busy_out !== 1'b0) give_verdict();
  endtask
  // One frame: command, address, n bytes sent (tx) or checked
  task automatic xfer(input logic [7:0] c, input logic [23:0] a, input int n,
                      input logic [63:0] e, input bit tx);
    wr(`HREG_CMD, {24'h0, c});
    wr(`HREG_ADDR, {8'h0, a});
    wr(`HREG_CTRL, 32'h1);
    idle();
    for (int i = n - 1; i >= 0; i--) begin
      if (tx) wr(`HREG_DATA, {24'h0, e[8*i +: 8]});
      wr(`HREG_CTRL, 32'h2);
      idle();
      rd(`HREG_DATA);
      if (!tx) chk(rdv, {24'h0, e[8*i +: 8]});
    end
    wr(`HREG_CTRL, 32'h4);
    idle();
  endtask
  // Identity reads, then secure page erase and program
  initial begin
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    xfer(`OP_JID, 0, 4, {MK, TY, CP, MK}, 0);
    xfer(`OP_ID_DUAL, 0, 4, {MK, DV, MK, DV}, 0);
    xfer(`OP_ID_QUAD, 0, 3, {MK, DV, MK}, 0);
    xfer(`OP_UID, 0, 8, UID, 0);
    xfer(`OP_PID, 24'h000010, 2, {PF, PF}, 0);
    xfer(`OP_SEC_ERASE, 24'h002000, 0, 0, 0);
    chk(busy_out, 0);
    xfer(`OP_WREN, 0, 0, 0, 0);
    @(posedge sys_clk_in) lock <= 3'h1;
    xfer(`OP_SEC_ERASE, 24'h001000, 0, 0, 0);
    chk({busy_out, write_enable_latch_bit}, 2'h1);
    xfer(`OP_SEC_ERASE, 24'h004000, 0, 0, 0);
    chk({busy_out, write_enable_latch_bit}, 2'h1);
    xfer(`OP_SEC_ERASE, 24'h002000, 1, 0, 1);
    chk({busy_out, write_enable_latch_bit}, 2'h1);
    xfer(`OP_SEC_ERASE, 24'h002000, 0, 0, 0);
    xfer(`OP_RDSR, 0, 1, 8'h03, 0);
    busy_wait();
    chk(write_enable_latch_bit, 0);
    xfer(`OP_WREN, 0, 0, 0, 0);
    xfer(`OP_SEC_PROG, 24'h002005, 1, 8'h5a, 1);
    busy_wait();
    xfer(`OP_SEC_READ, 24'h002005, 1, 8'h5a, 0);
    @(posedge sys_clk_in) susp <= 1'b1;
    xfer(`OP_WREN, 0, 0, 0, 0);
    xfer(`OP_SEC_PROG, 24'h002006, 1, 8'h00, 1);
    xfer(`OP_SEC_READ, 24'h002006, 1, 8'hff, 0);
    // Latch still set from the refused program; only suspend blocks this
    @(posedge sys_clk_in) esus <= 1'b1;
    xfer(`OP_SEC_ERASE, 24'h002000, 0, 0, 0);
    chk({busy_out, write_enable_latch_bit}, 2'h1);
    give_verdict();
  end
endmodule
